// file: hw/irc_ctrl.v
// Infrared carrier generator, timers, watchdog and standby control
// Overview of operation
// R1: Software switches carrier output on and off
// R2: Three carrier settings: 38k third, 38k half, 57k
// R3: Carrier source fixed by build option
// R4: Timer carrier spans 1 kHz to 200 kHz; the 16-bit period in 125 MHz clocks goes no lower than about 1.9 kHz
// R5: Carrier drives its own dedicated pin
// R6: Free-running timer requests halt release every 108 ms
// R7: Sixteen-bit timer clocked at oscillator rate
// R8: Watchdog present only when build option set
// R9: Light sleep stops execution, oscillator keeps running
// R10: Light sleep ends on reset or release
// R11: Deep sleep stops the resonator oscillation
// R12: Deep sleep ends on reset or enabled key high
// R13: Software sets wake flags before deep sleep
// R14: Oscillator stop command stops oscillator output
// R15: All four key-A inputs high cause reset
// R16: Reset holds carrier low, default 38k third
// R17: Active-low external reset with pull-up
// R18: Off carrier stays low, restarts on boundary
`timescale 1ns/1ps
`default_nettype none
`include "irc_ctrl_regs.vh"
module irc_ctrl #(
   parameter TIMER_CARRIER = 0,
   parameter WDT_USED = 1,
   parameter KEY_RESET_ALLOW = 1,
   parameter [31:0] HALT_CYCLES = `IRC_HALT_CYCLES,
   parameter [23:0] WDT_LIMIT = `IRC_WDT_LIMIT
) (
   // Clock and reset
   input wire clock_i,
   input wire rst_i,
   input wire ext_reset_n_i,
   // Carrier control
   input wire carrier_en_i,
   input wire [1:0] carrier_sel_i,
   input wire [15:0] carrier_period_i,
   input wire [15:0] carrier_high_i,
   // Software timer
   input wire timer_load_i,
   input wire [15:0] timer_value_i,
   input wire timer_run_i,
   // Watchdog and standby commands
   input wire wdt_clear_i,
   input wire halt_cmd_i,
   input wire hold_cmd_i,
   // Key inputs and wake permission
   input wire [3:0] key_in_a_i,
   input wire [3:0] key_in_b_i,
   input wire wake_en_a_i,
   input wire wake_en_b_i,
   // Outputs
   output reg carrier_out_pin_o,
   output reg halt_release_o,
   output reg [15:0] timer_count_o,
   output reg timer_overflow_o,
   output reg cpu_run_o,
   output reg osc_out_o,
   output reg sys_reset_o
);

   // Internal state
   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [31:0] halt_cnt_ff;
   reg [8:0] osc_div_ff;
   reg osc_tick_ff;
   reg [15:0] car_cnt_ff;
   reg [15:0] car_per_ff;
   reg [15:0] car_hi_ff;
   reg [23:0] wdt_cnt_ff;
   reg wdt_fire_ff;
   wire key_reset;
   wire reset_any;
   wire [15:0] car_period;
   wire [15:0] car_high;
   wire wake_key;
   wire [`IRC_KEY_BITS-1:0] wake_a_bits;
   wire [`IRC_KEY_BITS-1:0] wake_b_bits;
   wire car_wrap;
   wire deep_sleep;
   wire osc_wrap;
   wire halt_wrap;

   // Timing counts worked out in integers, then cut to counter widths
   localparam integer C38_PER_INT = `IRC_C38_PERIOD;
   localparam integer C57_PER_INT = `IRC_C57_PERIOD;
   localparam integer C38_THIRD_INT = `IRC_C38_PERIOD / `IRC_DUTY_THIRD;
   localparam integer C38_HALF_INT = `IRC_C38_PERIOD / `IRC_DUTY_HALF;
   localparam integer C57_HALF_INT = `IRC_C57_PERIOD / `IRC_DUTY_HALF;
   localparam integer OSC_LAST_INT = `IRC_SYSOSC_DIV - 1;
   localparam [15:0] C38_PER = C38_PER_INT[15:0];
   localparam [15:0] C57_PER = C57_PER_INT[15:0];
   localparam [15:0] C38_THIRD = C38_THIRD_INT[15:0];
   localparam [15:0] C38_HALF = C38_HALF_INT[15:0];
   localparam [15:0] C57_HALF = C57_HALF_INT[15:0];
   // Nine-bit divider: the tick ratio does not fit in eight bits
   localparam [8:0] OSC_LAST = OSC_LAST_INT[8:0];

   // Fixed carrier period lookup
   function [15:0] fixed_period;
      input [1:0] sel;
      begin
         case (sel)
            `IRC_SEL_57_HALF: fixed_period = C57_PER;
            default: fixed_period = C38_PER;
         endcase
      end
   endfunction

   // Fixed carrier high time lookup
   function [15:0] fixed_high;
      input [1:0] sel;
      begin
         case (sel)
            `IRC_SEL_38_HALF: fixed_high = C38_HALF;
            `IRC_SEL_57_HALF: fixed_high = C57_HALF;
            default: fixed_high = C38_THIRD;
         endcase
      end
   endfunction

   // Deep sleep decode, used by several processes
   function in_deep;
      input [1:0] st;
      begin
         in_deep = (st == `IRC_ST_HOLD);
      end
   endfunction

   // Reset sources combined
   assign key_reset = (KEY_RESET_ALLOW != 0) && (&key_in_a_i); // [R15]
   assign reset_any = rst_i | ~ext_reset_n_i | key_reset | wdt_fire_ff; // [R17]

   // Carrier source selected by build option
   assign car_period = (TIMER_CARRIER != 0) ? carrier_period_i :
                       fixed_period(carrier_sel_i); // [R3] [R2] [R4]
   assign car_high = (TIMER_CARRIER != 0) ? carrier_high_i :
                     fixed_high(carrier_sel_i); // [R2]

   // Per-pin wake qualification on both key ports
   genvar gi;
   generate
      for (gi = 0; gi < `IRC_KEY_BITS; gi = gi + 1) begin : g_wake
         assign wake_a_bits[gi] = wake_en_a_i & key_in_a_i[gi]; // [R12]
         assign wake_b_bits[gi] = wake_en_b_i & key_in_b_i[gi]; // [R12]
      end
   endgenerate

   // Deep sleep wake from any permitted key input
   assign wake_key = (|wake_a_bits) | (|wake_b_bits); // [R12]

   // Counter end points and sleep decode
   assign deep_sleep = in_deep(state_ff);
   assign osc_wrap = (osc_div_ff == OSC_LAST);
   assign halt_wrap = (halt_cnt_ff == HALT_CYCLES - 32'h00000001);
   assign car_wrap = (car_cnt_ff >= car_per_ff - 16'h0001);

   // Standby state machine
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `IRC_ST_RUN: begin
            if (hold_cmd_i) begin
               nxt_state = `IRC_ST_HOLD; // [R11] [R14]
            end else if (halt_cmd_i) begin
               nxt_state = `IRC_ST_HALT; // [R9]
            end
         end
         `IRC_ST_HALT: begin
            if (halt_release_o) begin
               nxt_state = `IRC_ST_RUN; // [R10]
            end
         end
         `IRC_ST_HOLD: begin
            if (wake_key) begin
               nxt_state = `IRC_ST_RUN; // [R12]
            end
         end
         default: nxt_state = `IRC_ST_RUN;
      endcase
   end

   // Standby state register
   always @(posedge clock_i) begin
      if (reset_any) begin
         state_ff <= `IRC_ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Run flag and reset indication, registered for the pins
   always @(posedge clock_i) begin
      if (reset_any) begin
         cpu_run_o <= 1'b1;
         sys_reset_o <= 1'b1;
      end else begin
         cpu_run_o <= (nxt_state == `IRC_ST_RUN); // [R9]
         sys_reset_o <= 1'b0;
      end
   end

   // Oscillator output toggles except in deep sleep
   always @(posedge clock_i) begin
      if (reset_any) begin
         osc_out_o <= 1'b0;
      end else if (in_deep(nxt_state)) begin
         osc_out_o <= 1'b0; // [R11] [R14]
      end else begin
         osc_out_o <= ~osc_out_o; // [R9]
      end
   end

   // System oscillator tick, frozen in deep sleep
   always @(posedge clock_i) begin
      if (reset_any) begin
         osc_div_ff <= 9'h000;
         osc_tick_ff <= 1'b0;
      end else if (deep_sleep) begin
         osc_div_ff <= 9'h000;
         osc_tick_ff <= 1'b0;
      end else if (osc_wrap) begin
         osc_div_ff <= 9'h000;
         osc_tick_ff <= 1'b1; // [R7]
      end else begin
         osc_div_ff <= osc_div_ff + 9'h001;
         osc_tick_ff <= 1'b0;
      end
   end

   // Free-running halt release timer
   always @(posedge clock_i) begin
      if (reset_any || deep_sleep) begin
         halt_cnt_ff <= 32'h00000000;
         halt_release_o <= 1'b0;
      end else if (halt_wrap) begin
         halt_cnt_ff <= 32'h00000000;
         halt_release_o <= 1'b1; // [R6]
      end else begin
         halt_cnt_ff <= halt_cnt_ff + 32'h00000001;
         halt_release_o <= 1'b0;
      end
   end

   // Software 16-bit timer
   always @(posedge clock_i) begin
      if (reset_any) begin
         timer_count_o <= 16'h0000;
         timer_overflow_o <= 1'b0;
      end else if (timer_load_i) begin
         timer_count_o <= timer_value_i;
         timer_overflow_o <= 1'b0;
      end else if (timer_run_i && osc_tick_ff) begin
         timer_count_o <= timer_count_o + 16'h0001; // [R7]
         timer_overflow_o <= (timer_count_o == 16'hFFFF);
      end else begin
         timer_overflow_o <= 1'b0;
      end
   end

   // Watchdog, present only when built in
   // Count cleared while asleep, so a long sleep never trips it
   always @(posedge clock_i) begin
      if (rst_i || !ext_reset_n_i || key_reset || wdt_fire_ff || WDT_USED == 0) begin
         wdt_cnt_ff <= 24'h000000;
         wdt_fire_ff <= 1'b0;
      end else if (wdt_clear_i || state_ff != `IRC_ST_RUN) begin
         wdt_cnt_ff <= 24'h000000;
      end else if (wdt_cnt_ff == WDT_LIMIT) begin
         wdt_fire_ff <= 1'b1; // [R8]
      end else begin
         wdt_cnt_ff <= wdt_cnt_ff + 24'h000001;
      end
   end

   // Carrier generator on dedicated pin; settings change at a period boundary, or at once while off or in deep sleep
   always @(posedge clock_i) begin
      if (reset_any) begin
         car_cnt_ff <= 16'h0000;
         car_per_ff <= C38_PER; // [R16]
         car_hi_ff <= C38_THIRD; // [R16]
         carrier_out_pin_o <= 1'b0; // [R16]
      end else if (!carrier_en_i || deep_sleep) begin
         car_cnt_ff <= 16'h0000; // [R18]
         car_per_ff <= car_period;
         car_hi_ff <= car_high;
         carrier_out_pin_o <= 1'b0; // [R1] [R18]
      end else begin
         if (car_wrap) begin
            car_cnt_ff <= 16'h0000;
            car_per_ff <= car_period; // [R18]
            car_hi_ff <= car_high;
         end else begin
            car_cnt_ff <= car_cnt_ff + 16'h0001;
         end
         carrier_out_pin_o <= (car_cnt_ff < car_hi_ff); // [R5] [R2]
      end
   end

endmodule // irc_ctrl
`default_nettype wire

// file: hw/irc_ctrl_regs.vh
// Constants for the infrared carrier and standby control block
`ifndef IRC_CTRL_REGS_VH
`define IRC_CTRL_REGS_VH
`define IRC_CLK_HZ 125000000
`define IRC_SYSOSC_HZ 455000
`define IRC_C38_HZ 38000
`define IRC_C57_HZ 57000
`define IRC_HALT_PERIOD_MS 108
`define IRC_DUTY_THIRD 3
`define IRC_DUTY_HALF 2
`define IRC_KEY_BITS 4
`define IRC_SYSOSC_DIV ((`IRC_CLK_HZ + `IRC_SYSOSC_HZ - 1) / `IRC_SYSOSC_HZ)
`define IRC_C38_PERIOD (`IRC_CLK_HZ / `IRC_C38_HZ)
`define IRC_C57_PERIOD (`IRC_CLK_HZ / `IRC_C57_HZ)
`define IRC_HALT_CYCLES (`IRC_CLK_HZ / 1000 * `IRC_HALT_PERIOD_MS)
`define IRC_SEL_38_THIRD 2'h0
`define IRC_SEL_38_HALF 2'h1
`define IRC_SEL_57_HALF 2'h2
`define IRC_ST_RUN 2'h0
`define IRC_ST_HALT 2'h1
`define IRC_ST_HOLD 2'h2
`define IRC_WDT_LIMIT 24'hFFFFFF
`endif

// file: tb/irc_ctrl_assertions.sv
// Checker for the carrier and standby block
`timescale 1ns/1ps
`default_nettype none
module irc_chk (
   // Clock and resets
   input wire logic clock_i, rst_i, ext_reset_n_i,
   // Commands and keys
   input wire logic carrier_en_i, halt_cmd_i, hold_cmd_i, wake_en_a_i, wake_en_b_i,
   input wire logic [3:0] key_in_a_i, key_in_b_i,
   // Outputs
   input wire logic carrier_out_pin_o, halt_release_o, cpu_run_o, osc_out_o, sys_reset_o
);
   reg deep_ff;
   wire ok = !rst_i && ext_reset_n_i && !(&key_in_a_i);
   wire kw = wake_en_a_i && |key_in_a_i || wake_en_b_i && |key_in_b_i;
   // Sleep kind chosen when leaving run
   always @(posedge clock_i) begin
      if (cpu_run_o) deep_ff <= hold_cmd_i;
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   property p_off; !carrier_en_i |=> !carrier_out_pin_o; endproperty
   a_off: assert property (p_off) else $error("pin on while off");
   property p_ext; !ext_reset_n_i |=> sys_reset_o && !carrier_out_pin_o; endproperty
   a_ext: assert property (p_ext) else $error("ext reset");
   property p_halt; cpu_run_o && halt_cmd_i && ok |=> !cpu_run_o; endproperty
   a_halt: assert property (p_halt) else $error("no sleep");
   property p_losc; !cpu_run_o && !deep_ff && ok |=> osc_out_o != $past(osc_out_o); endproperty
   a_losc: assert property (p_losc) else $error("osc stopped");
   property p_lwk; !cpu_run_o && !deep_ff && ok |=> cpu_run_o == $past(halt_release_o); endproperty
   a_lwk: assert property (p_lwk) else $error("light wake");
   property p_dosc; !cpu_run_o && deep_ff && ok && !kw |=> !osc_out_o; endproperty
   a_dosc: assert property (p_dosc) else $error("osc runs");
   property p_dwk; !cpu_run_o && deep_ff && ok |=> cpu_run_o == $past(kw); endproperty
   a_dwk: assert property (p_dwk) else $error("deep wake");
   property p_key; &key_in_a_i |=> sys_reset_o; endproperty
   a_key: assert property (p_key) else $error("key reset");
   cover property (!cpu_run_o && !deep_ff && halt_release_o);
   cover property (!cpu_run_o && deep_ff && kw);
   cover property ($rose(carrier_out_pin_o));
endmodule // irc_chk
bind irc_ctrl irc_chk u_chk (.*);
`default_nettype wire

// file: tb/irc_partner.sv
// LED driver and key switch model
`timescale 1ns/1ps
`default_nettype none
module irc_partner (
   // Clock and bench control
   input wire logic clock_i, clr_i,
   input wire logic [7:0] press_i,
   // Device side
   input wire logic carrier_i,
   output logic [3:0] key_a_o, key_b_o,
   output logic [15:0] high_cnt_o
);
   // Open keys sit at the pull-down level
   assign key_a_o = press_i[3:0];
   assign key_b_o = press_i[7:4];
   // LED on-time in clocks
   always @(posedge clock_i) begin
      if (clr_i) high_cnt_o <= 16'h0;
      else high_cnt_o <= high_cnt_o + {15'h0, carrier_i};
   end
endmodule // irc_partner
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the carrier and standby block
`timescale 1ns/1ps
`default_nettype none
`include "irc_ctrl_regs.vh"
module testbench;
   logic clock_i = 0, rst_i = 1, ext_n = 1, car_en = 0, t_load = 0, t_run = 0;
   logic halt = 0, hold = 0, wen = 0, clr = 0, o, wclr = 1, wen_b = 0;
   logic [15:0] tval = 16'hFFFF;
   logic [1:0] sel = 0;
   logic [7:0] press = 0;
   logic [3:0] ka, kb;
   logic [15:0] hcnt;
   wire [15:0] tcnt;
   wire car, hrel, ovf, run, osc, srst;
   int num_errors = 0, cmp_count = 0, cyc = 0, i, k, p;
   always #4 clock_i = ~clock_i;
   irc_ctrl #(.HALT_CYCLES(32'h64), .WDT_USED(1), .WDT_LIMIT(24'h32)) DUT (.clock_i(clock_i),
      .rst_i(rst_i), .ext_reset_n_i(ext_n), .carrier_en_i(car_en), .carrier_sel_i(sel),
      .carrier_period_i(16'h0), .carrier_high_i(16'h0), .timer_load_i(t_load),
      .timer_value_i(tval), .timer_run_i(t_run), .wdt_clear_i(wclr), .halt_cmd_i(halt),
      .hold_cmd_i(hold), .key_in_a_i(ka), .key_in_b_i(kb), .wake_en_a_i(wen),
      .wake_en_b_i(wen_b), .carrier_out_pin_o(car), .halt_release_o(hrel),
      .timer_count_o(tcnt), .timer_overflow_o(ovf), .cpu_run_o(run), .osc_out_o(osc),
      .sys_reset_o(srst));
   irc_partner P (.clock_i(clock_i), .clr_i(clr), .press_i(press), .carrier_i(car),
      .key_a_o(ka), .key_b_o(kb), .high_cnt_o(hcnt));
   task nx(input int n);
      repeat (n) @(negedge clock_i);
   endtask
   task chk(input string n, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task wh;
      for (i = 1; i < 300 && hrel !== 1'b1; i++) nx(1);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         finish_test;
      end
   end
   initial begin
      nx(3);
      rst_i = 0;
      nx(1);
      chk("pin", 0, car);
      chk("run", 1, run);
      for (k = 0; k < 3; k++) begin
         p = k == 2 ? `IRC_C57_PERIOD : `IRC_C38_PERIOD;
         sel = k[1:0];
         clr = 1;
         nx(1);
         clr = 0;
         car_en = 1;
         nx(1);
         chk("pin start", 1, car);
         nx(p);
         car_en = 0;
         chk("high", k == 0 ? p / 3 : p / 2, hcnt);
         nx(2);
         chk("pin off", 0, car);
      end
      wh;
      nx(1);
      wh;
      chk("period", 100, i);
      halt = 1;
      nx(1);
      halt = 0;
      chk("halt run", 0, run);
      o = osc;
      nx(1);
      chk("halt osc", {15'h0, ~o}, osc);
      wh;
      nx(1);
      chk("halt wake", 1, run);
      wen = 1;
      hold = 1;
      halt = 1;
      nx(1);
      {hold, halt} = 0;
      nx(150);
      chk("hold run", 0, run);
      chk("hold osc", 0, osc);
      press = 8'h01;
      nx(1);
      chk("hold wake", 1, run);
      press = 0;
      wen = 0;
      wen_b = 1;
      hold = 1;
      nx(1);
      hold = 0;
      press = 8'h01;
      nx(3);
      chk("gate", 0, run);
      press = 8'h10;
      nx(1);
      chk("b wake", 1, run);
      press = 0;
      t_load = 1;
      t_run = 1;
      nx(1);
      t_load = 0;
      chk("load", 16'hFFFF, tcnt);
      for (i = 0; i < 300 && ovf !== 1'b1; i++) nx(1);
      chk("wrap", 0, tcnt);
      chk("ovf", 1, ovf);
      for (i = 0; i < 300 && tcnt !== 16'h0001; i++) nx(1);
      chk("tick", `IRC_SYSOSC_DIV, i);
      // Limit 50: count reaches it, fire flag, then reset shows
      wclr = 0;
      for (i = 0; i < 300 && srst !== 1'b1; i++) nx(1);
      wclr = 1;
      chk("wdt", 16'h34, i);
      chk("wdt tmr", 0, tcnt);
      press = 8'h0F;
      nx(1);
      chk("key rst", 1, srst);
      press = 0;
      ext_n = 0;
      car_en = 1;
      nx(1);
      chk("ext rst", 1, srst);
      chk("rst pin", 0, car);
      ext_n = 1;
      car_en = 0;
      nx(2);
      chk("rst off", 0, srst);
      finish_test;
   end
endmodule // testbench
`default_nettype wire
